// [include/crr_regs.svh]
`ifndef CRR_REGS_SVH
`define CRR_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register map, byte addresses on the APB
`define CRR_ADDR_W            12
`define CRR_OFF_CTRL          12'h000
`define CRR_OFF_TBL_INDEX     12'h004
`define CRR_OFF_TBL_DATA      12'h008
`define CRR_OFF_ROT_COUNT     12'h00c
`define CRR_OFF_LAST_CLASS    12'h010

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CRR_CTRL_ENA_BIT      0
`define CRR_CTRL_RST          1'h1
`define CRR_PTR_W             3
`define CRR_PTR_CNT           3
`define CRR_SLOT1_LO          0
`define CRR_SLOT2_LO          3
`define CRR_SLOT3_LO          6
`define CRR_ENTRY_W           9
`define CRR_INDEX_W           9
`define CRR_ENTRIES           512
`define CRR_MASK_W            8
`define CRR_CLASS_MOD         8
`define CRR_SEL_W             2
`define CRR_TS_W              3
`define CRR_TS_INJECTION_LOOPBACK_MODE_DFLT   3'h1
`define CRR_CNT_W             16

////////////////////////////////////////////////////////////////////////////////
// Constant values
`define CRR_SEL_OFF           2'h0
`define CRR_INDEX_NONE        9'h000
`define CRR_MASK_NONE         8'h00
`define CRR_PTR_RST           3'h0
`define CRR_ENTRY_RST         9'h000
`define CRR_CNT_RST           16'h0000
`define CRR_CNT_ONE           16'h0001
`define CRR_DATA_ZERO         32'h00000000

`endif

// [include/crr_pkg.sv]
package crr_pkg;
	typedef logic [2:0]  crr_ptr_t;
	typedef logic [2:0]  crr_class_t;
	typedef logic [8:0]  crr_entry_t;
	typedef logic [8:0]  crr_index_t;
	typedef logic [7:0]  crr_mask_t;
	typedef logic [1:0]  crr_sel_t;
endpackage

// [core/crr_pick.sv]
`include "crr_regs.svh"

module crr_pick
	import crr_pkg::*;
(
	input  wire crr_mask_t  mask,
	input  wire crr_ptr_t   start,
	output crr_class_t      class_new,
	output crr_ptr_t        ptr_next
);

	////////////////////////////////////////////////////////////////////////////
	// Circular scan from start, first set bit wins
	always_comb begin
		logic       found;
		crr_class_t cand;
		found     = 1'b0;
		cand      = start;
		class_new = start;
		for (int i = 0; i < `CRR_CLASS_MOD; i++) begin
			cand = crr_class_t'(start + crr_class_t'(i));
			if (!found && mask[cand]) begin
				found     = 1'b1;
				class_new = cand;
			end
		end
		ptr_next = crr_ptr_t'(class_new + crr_class_t'(1));
	end

endmodule

// [core/crr_rewriter.sv]
// The implementer's own choices: the APB slave port and the placing of the registers.
`include "crr_regs.svh"

// Notes on behaviour
// - Rotate only when selector, service index and class mask are all non-zero.
// - New class is first set mask bit scanning circularly from stored pointer.
// - Table of 512 service indexes, three independent next pointers each.
// - Per-frame enables pick class, outer priority, traffic class, user priority updates.
// - Up-facing frames are changed on their first rewriter pass.
// - First up-facing pass clears the selector so the looped frame stays unchanged.
// - Down-facing frames get the new class in enabled internal fields.
// - Down-facing frames ignore outer enable; outer priority comes from tagging config.
module crr_rewriter
	import crr_pkg::*;
#(
	parameter logic [`CRR_TS_W-1:0] TS_INJECTION_LOOPBACK_MODE = `CRR_TS_INJECTION_LOOPBACK_MODE_DFLT
)
(
	input  wire logic                    ref_clk,
	input  wire logic                    arst_n,
	// APB slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`CRR_ADDR_W-1:0]  paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Frame in
	input  wire logic                    in_valid,
	output logic                         in_ready,
	input  wire logic [`CRR_TS_W-1:0]    timestamp_mode_field,
	input  wire crr_sel_t                in_sel,
	input  wire crr_index_t              in_index,
	input  wire crr_mask_t               in_mask,
	input  wire logic                    update_class_field_en,
	input  wire logic                    update_outer_priority_en,
	input  wire logic                    update_label_traffic_class_en,
	input  wire logic                    update_user_priority_en,
	input  wire logic                    in_on_virtual_loopback_port,
	input  wire crr_class_t              in_class_field,
	input  wire crr_class_t              in_outer_priority,
	input  wire crr_class_t              in_label_traffic_class_field,
	input  wire crr_class_t              in_user_priority_field,
	input  wire crr_class_t              tag_cfg_outer_priority,
	// Frame out
	output logic                         out_valid,
	input  wire logic                    out_ready,
	output crr_sel_t                     out_sel,
	output crr_class_t                   out_class_field,
	output crr_class_t                   out_outer_priority,
	output crr_class_t                   out_label_traffic_class_field,
	output crr_class_t                   out_user_priority_field,
	output logic                         out_rotated
);

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	crr_entry_t                  tbl_reg [`CRR_ENTRIES];
	logic                        ena_reg;
	crr_index_t                  tbl_index_reg;
	logic [`CRR_CNT_W-1:0]       rot_count_reg;
	crr_class_t                  last_class_reg;
	logic                        out_valid_reg;
	crr_sel_t                    out_sel_reg;
	crr_class_t                  out_class_reg;
	crr_class_t                  out_outer_reg;
	crr_class_t                  out_tc_reg;
	crr_class_t                  out_user_priority_field_reg;
	logic                        out_rot_reg;
	logic [31:0]                 prdata_reg;
	logic                        pslverr_reg;

	logic                        take;
	logic                        rot_act;
	crr_sel_t                    ptr_slot;
	crr_entry_t                  cur_entry;
	crr_ptr_t                    cur_ptr;
	crr_class_t                  class_new;
	crr_ptr_t                    ptr_next;
	crr_entry_t                  entry_next;
	logic                        apb_setup;
	logic                        apb_wr;
	logic                        hit_ctrl;
	logic                        hit_index;
	logic                        hit_data;
	logic                        hit_count;
	logic                        hit_last;
	logic                        hit_any;

	////////////////////////////////////////////////////////////////////////////
	// Frame handshake
	assign in_ready = !out_valid_reg || out_ready;
	assign take     = in_valid && in_ready;

	////////////////////////////////////////////////////////////////////////////
	// Rotation decision and pointer fetch
	assign rot_act = ena_reg && (timestamp_mode_field == TS_INJECTION_LOOPBACK_MODE)
		&& (in_sel != `CRR_SEL_OFF) && (in_index != `CRR_INDEX_NONE)
		&& (in_mask != `CRR_MASK_NONE);

	assign ptr_slot  = crr_sel_t'(in_sel - crr_sel_t'(1));
	assign cur_entry = tbl_reg[in_index];

	// Pointer select, kept apart from the write-back to avoid a false loop
	always_comb begin
		unique case (ptr_slot)
			2'h0:    cur_ptr = cur_entry[`CRR_SLOT1_LO +: `CRR_PTR_W];
			2'h1:    cur_ptr = cur_entry[`CRR_SLOT2_LO +: `CRR_PTR_W];
			2'h2:    cur_ptr = cur_entry[`CRR_SLOT3_LO +: `CRR_PTR_W];
			default: cur_ptr = cur_entry[`CRR_SLOT1_LO +: `CRR_PTR_W];
		endcase
	end

	// Entry with the selected pointer replaced
	always_comb begin
		entry_next = cur_entry;
		unique case (ptr_slot)
			2'h0:    entry_next[`CRR_SLOT1_LO +: `CRR_PTR_W] = ptr_next;
			2'h1:    entry_next[`CRR_SLOT2_LO +: `CRR_PTR_W] = ptr_next;
			2'h2:    entry_next[`CRR_SLOT3_LO +: `CRR_PTR_W] = ptr_next;
			default: entry_next = cur_entry;
		endcase
	end

	crr_pick u_pick (
		.mask      (in_mask),
		.start     (cur_ptr),
		.class_new (class_new),
		.ptr_next  (ptr_next)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB decode
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign hit_ctrl  = (paddr == `CRR_OFF_CTRL);
	assign hit_index = (paddr == `CRR_OFF_TBL_INDEX);
	assign hit_data  = (paddr == `CRR_OFF_TBL_DATA);
	assign hit_count = (paddr == `CRR_OFF_ROT_COUNT);
	assign hit_last  = (paddr == `CRR_OFF_LAST_CLASS);
	assign hit_any   = hit_ctrl || hit_index || hit_data || hit_count || hit_last;

	assign pready  = psel && penable;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg && psel && penable;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_reg  <= `CRR_DATA_ZERO;
			pslverr_reg <= 1'b0;
		end else if (apb_setup) begin
			pslverr_reg <= !hit_any || (pwrite && (hit_count || hit_last));
			prdata_reg  <= `CRR_DATA_ZERO;
			if (hit_ctrl)
				prdata_reg[`CRR_CTRL_ENA_BIT] <= ena_reg;
			if (hit_index)
				prdata_reg[`CRR_INDEX_W-1:0] <= tbl_index_reg;
			if (hit_data)
				prdata_reg[`CRR_ENTRY_W-1:0] <= tbl_reg[tbl_index_reg];
			if (hit_count)
				prdata_reg[`CRR_CNT_W-1:0] <= rot_count_reg;
			if (hit_last)
				prdata_reg[`CRR_PTR_W-1:0] <= last_class_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control registers
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ena_reg <= `CRR_CTRL_RST;
		end else if (apb_wr && hit_ctrl) begin
			ena_reg <= pwdata[`CRR_CTRL_ENA_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tbl_index_reg <= `CRR_INDEX_NONE;
		end else if (apb_wr && hit_index) begin
			tbl_index_reg <= pwdata[`CRR_INDEX_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pointer table, frame update beats software write
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < `CRR_ENTRIES; i++) begin
				tbl_reg[i] <= `CRR_ENTRY_RST;
			end
		end else begin
			for (int i = 0; i < `CRR_ENTRIES; i++) begin
				if (take && rot_act && (in_index == crr_index_t'(i))) begin
					tbl_reg[i] <= entry_next;
				end else if (apb_wr && hit_data && (tbl_index_reg == crr_index_t'(i))) begin
					tbl_reg[i] <= pwdata[`CRR_ENTRY_W-1:0];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rot_count_reg  <= `CRR_CNT_RST;
			last_class_reg <= `CRR_PTR_RST;
		end else if (take && rot_act) begin
			rot_count_reg  <= rot_count_reg + `CRR_CNT_ONE;
			last_class_reg <= class_new;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output frame fields
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_valid_reg <= 1'b0;
		end else if (in_ready) begin
			out_valid_reg <= in_valid;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_rot_reg <= 1'b0;
		end else if (take) begin
			out_rot_reg <= rot_act;
		end
	end

	// Selector, cleared on the first up-facing pass
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_sel_reg <= `CRR_SEL_OFF;
		end else if (take) begin
			if (rot_act && in_on_virtual_loopback_port)
				out_sel_reg <= `CRR_SEL_OFF;
			else
				out_sel_reg <= in_sel;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_class_reg <= `CRR_PTR_RST;
		end else if (take) begin
			if (rot_act && update_class_field_en)
				out_class_reg <= class_new;
			else
				out_class_reg <= in_class_field;
		end
	end

	// Outer priority, tagging config wins on down-facing frames
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_outer_reg <= `CRR_PTR_RST;
		end else if (take) begin
			if (rot_act && !in_on_virtual_loopback_port)
				out_outer_reg <= tag_cfg_outer_priority;
			else if (rot_act && update_outer_priority_en)
				out_outer_reg <= class_new;
			else
				out_outer_reg <= in_outer_priority;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_tc_reg <= `CRR_PTR_RST;
		end else if (take) begin
			if (rot_act && update_label_traffic_class_en)
				out_tc_reg <= class_new;
			else
				out_tc_reg <= in_label_traffic_class_field;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_user_priority_field_reg <= `CRR_PTR_RST;
		end else if (take) begin
			if (rot_act && update_user_priority_en)
				out_user_priority_field_reg <= class_new;
			else
				out_user_priority_field_reg <= in_user_priority_field;
		end
	end

	assign out_valid                     = out_valid_reg;
	assign out_sel                       = out_sel_reg;
	assign out_class_field               = out_class_reg;
	assign out_outer_priority            = out_outer_reg;
	assign out_label_traffic_class_field = out_tc_reg;
	assign out_user_priority_field       = out_user_priority_field_reg;
	assign out_rotated                   = out_rot_reg;

endmodule

// [verification/crr_rewriter_chk.sv]
module crr_chk
	import crr_pkg::*;
#(
	parameter logic [2:0] TS_INJECTION_LOOPBACK_MODE = 3'h1
)
(
	input wire logic       ref_clk,
	input wire logic       arst_n,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       in_valid,
	input wire logic       in_ready,
	input wire logic [2:0] timestamp_mode_field,
	input wire crr_sel_t   in_sel,
	input wire crr_index_t in_index,
	input wire crr_mask_t  in_mask,
	input wire logic       update_class_field_en,
	input wire logic       update_label_traffic_class_en,
	input wire logic       in_on_virtual_loopback_port,
	input wire crr_class_t in_label_traffic_class_field,
	input wire crr_class_t tag_cfg_outer_priority,
	input wire logic       out_valid,
	input wire logic       out_ready,
	input wire crr_sel_t   out_sel,
	input wire crr_class_t out_class_field,
	input wire crr_class_t out_outer_priority,
	input wire crr_class_t out_label_traffic_class_field,
	input wire logic       out_rotated
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	sequence s_take; in_valid && in_ready; endsequence
	sequence s_stall; out_valid && !out_ready; endsequence
	////////////////////////////////////////////////////////////////////////////////
	a_ready_flow: assert property (in_ready == (!out_valid || out_ready)) else $error("in_ready wrong");
	a_apb_ready: assert property (pready == (psel && penable)) else $error("pready wrong");
	a_out_hold: assert property (s_stall |=> out_valid && $stable(out_sel) && $stable(out_class_field))
		else $error("output not held");
	a_take_out: assert property (s_take |=> out_valid) else $error("no output after take");
	a_no_rot: assert property (s_take ##0 (in_sel == 2'h0 || in_index == 9'h000 || in_mask == 8'h00)
		|=> !out_rotated && out_sel == $past(in_sel)) else $error("rotated when disabled");
	a_ts_gate: assert property (s_take ##0 timestamp_mode_field != TS_INJECTION_LOOPBACK_MODE |=> !out_rotated)
		else $error("rotated with wrong mode");
	a_mask_hit: assert property (s_take ##0 update_class_field_en
		|=> !out_rotated || (($past(in_mask) >> out_class_field) & 8'h01) != 8'h00) else $error("class not in mask");
	a_up_sel: assert property (s_take ##0 in_on_virtual_loopback_port |=> !out_rotated || out_sel == 2'h0)
		else $error("selector not cleared");
	a_down_outer: assert property (s_take ##0 !in_on_virtual_loopback_port
		|=> !out_rotated || out_outer_priority == $past(tag_cfg_outer_priority)) else $error("outer priority wrong");
	a_tc_keep: assert property (s_take ##0 !update_label_traffic_class_en
		|=> out_label_traffic_class_field == $past(in_label_traffic_class_field)) else $error("traffic class changed");
endmodule

bind crr_rewriter crr_chk #(.TS_INJECTION_LOOPBACK_MODE(TS_INJECTION_LOOPBACK_MODE)) chk_u (.*);

// [verification/crr_sink.sv]
module crr_sink
(
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic stall_en,
	output logic      out_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	// Analyzer side, stalls at random
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			out_ready <= 1'b0;
		else
			out_ready <= !stall_en || ($urandom % 3 != 0);
	end
endmodule

// [verification/crr_rewriter_test.sv]
module crr_rewriter_test
	import crr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [2:0] TSL = 3'h1;
	logic        ref_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, in_valid = 1'b0, in_ready, vlp = 1'b0, stall_en = 1'b0, ctrl_en = 1'b1;
	logic        out_valid, out_ready, out_rotated;
	logic [3:0]  en = 4'h0;
	logic [2:0]  ts = 3'h0;
	crr_sel_t    sel = 2'h0, out_sel;
	crr_index_t  idx = 9'h000;
	crr_mask_t   mask = 8'h00;
	crr_class_t  c_in = 3'h0, o_in = 3'h0, t_in = 3'h0, u_in = 3'h0, tag = 3'h0, c_o, o_o, t_o, u_o, last_c = 3'h0;
	crr_ptr_t    ptr [512][3];
	logic [14:0] expq [$];
	int          err_count = 0, cmp_count = 0, rot_n = 0;

	always #25 ref_clk = ~ref_clk;
	crr_rewriter #(.TS_INJECTION_LOOPBACK_MODE(TSL)) dut_u (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .in_valid, .in_ready, .timestamp_mode_field(ts), .in_sel(sel), .in_index(idx),
		.in_mask(mask), .update_class_field_en(en[0]), .update_outer_priority_en(en[1]),
		.update_label_traffic_class_en(en[2]), .update_user_priority_en(en[3]), .in_on_virtual_loopback_port(vlp),
		.in_class_field(c_in), .in_outer_priority(o_in), .in_label_traffic_class_field(t_in),
		.in_user_priority_field(u_in), .tag_cfg_outer_priority(tag), .out_valid, .out_ready, .out_sel,
		.out_class_field(c_o), .out_outer_priority(o_o), .out_label_traffic_class_field(t_o),
		.out_user_priority_field(u_o), .out_rotated);
	crr_sink sink_u (.ref_clk, .arst_n, .stall_en, .out_ready);
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(string nm, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [31:0] er, logic ee, string nm);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			check("apb_timeout", 32'h0, 32'h1);
			summarize();
		end
		if (!wr)
			check(nm, er, prdata);
		check("pslverr", {31'h0, ee}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic frame();
		crr_class_t nc;
		crr_ptr_t   p;
		logic       rot;
		int         n;
		in_valid <= 1'b1;
		sel <= 2'($urandom);
		idx <= 9'($urandom % 8);
		mask <= ($urandom % 5 == 0) ? 8'h00 : 8'($urandom);
		ts <= ($urandom % 6 == 0) ? 3'h2 : TSL;
		en <= 4'($urandom);
		vlp <= 1'($urandom);
		c_in <= 3'($urandom);
		o_in <= 3'($urandom);
		t_in <= 3'($urandom);
		u_in <= 3'($urandom);
		tag <= 3'($urandom);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (in_ready !== 1'b1 && n < 50);
		if (n >= 50) begin
			check("frame_timeout", 32'h0, 32'h1);
			summarize();
		end
		rot = ctrl_en && ts == TSL && sel != 2'h0 && idx != 9'h000 && mask != 8'h00;
		nc = 3'h0;
		if (rot) begin
			p = ptr[idx][sel - 1];
			for (int i = 7; i >= 0; i--)
				if (mask[3'(p + i)])
					nc = 3'(p + i);
			ptr[idx][sel - 1] = nc + 3'h1;
			rot_n++;
			last_c = nc;
		end
		expq.push_back({(rot && vlp) ? 2'h0 : sel, (rot && en[0]) ? nc : c_in,
			rot ? (vlp ? (en[1] ? nc : o_in) : tag) : o_in, (rot && en[2]) ? nc : t_in, (rot && en[3]) ? nc : u_in, rot});
		@(posedge ref_clk);
	endtask

	always @(negedge ref_clk) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			if (expq.size() == 0)
				check("frame_extra", 32'h0, 32'h1);
			else
				check("frame", {17'h0, expq.pop_front()}, {17'h0, out_sel, c_o, o_o, t_o, u_o, out_rotated});
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h8b8a));
		foreach (ptr[i, j])
			ptr[i][j] = 3'h0;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		apb(1'b0, 12'h000, 32'h0, 32'h1, 1'b0, "ctrl_rst");
		apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0, "tbl_rst");
		apb(1'b0, 12'h00c, 32'h0, 32'h0, 1'b0, "count_rst");
		apb(1'b0, 12'h014, 32'h0, 32'h0, 1'b1, "unmapped");
		apb(1'b1, 12'h00c, 32'h5, 32'h0, 1'b1, "ro_write");
		apb(1'b1, 12'h004, 32'h5, 32'h0, 1'b0, "tbl_index");
		apb(1'b1, 12'h008, 32'h1fa, 32'h0, 1'b0, "tbl_write");
		ptr[5][0] = 3'h2;
		ptr[5][1] = 3'h7;
		ptr[5][2] = 3'h7;
		apb(1'b0, 12'h008, 32'h0, 32'h1fa, 1'b0, "tbl_read");
		stall_en <= 1'b1;
		repeat (400) frame();
		in_valid <= 1'b0;
		apb(1'b0, 12'h00c, 32'h0, {16'h0, rot_n[15:0]}, 1'b0, "rot_count");
		apb(1'b0, 12'h010, 32'h0, {29'h0, last_c}, 1'b0, "last_class");
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 12'h004, 32'(i), 32'h0, 1'b0, "tbl_index");
			apb(1'b0, 12'h008, 32'h0, {23'h0, ptr[i][2], ptr[i][1], ptr[i][0]}, 1'b0, "tbl_ptrs");
		end
		apb(1'b1, 12'h000, 32'h0, 32'h0, 1'b0, "ctrl_off");
		ctrl_en = 1'b0;
		repeat (30) frame();
		in_valid <= 1'b0;
		for (int n = 0; n < 200 && expq.size() != 0; n++)
			@(posedge ref_clk);
		check("drain", 32'h0, 32'(expq.size()));
		summarize();
	end
endmodule
